// *** prom_pkg.sv ***
package prom_pkg;
  localparam int WORD_COUNT = 4096;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  localparam int CLK_MHZ = 125;
  // shortest program supply pulse that blows a fuse, in microseconds
  localparam int FIRST_PULSE_WIDTH_MIN_US = 10;
  localparam int PULSE_MIN_CYC = FIRST_PULSE_WIDTH_MIN_US * CLK_MHZ;
  localparam int PULSE_CNT_W = 12;
endpackage : prom_pkg

// *** registered_prom_read_program.sv ***
module registered_prom_read_program #(
  parameter int DEPTH = prom_pkg::WORD_COUNT,
  parameter int AW = prom_pkg::ADDR_W,
  parameter int DW = prom_pkg::DATA_W,
  parameter logic [prom_pkg::PULSE_CNT_W-1:0] PULSE_MIN_CYC =
    prom_pkg::PULSE_CNT_W'(prom_pkg::PULSE_MIN_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [prom_pkg::ADDR_W-1:0] word_address,
  input wire logic reg_load_clk,
  input wire logic output_enable_n,
  input wire logic program_supply_pulse,
  input wire logic [prom_pkg::DATA_W-1:0] program_load,
  output logic [prom_pkg::DATA_W-1:0] data_outputs,
  output logic [prom_pkg::DATA_W-1:0] data_outputs_oe
);
  import prom_pkg::*;

  localparam int CW = PULSE_CNT_W;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] fuse;
    logic [AW-1:0] addr_s1;
    logic [AW-1:0] addr_s2;
    logic rclk_s1;
    logic rclk_s2;
    logic rclk_d;
    logic oe_n_s1;
    logic oe_n_s2;
    logic sup_s1;
    logic sup_s2;
    logic sup_d;
    logic [DW-1:0] load_s1;
    logic [DW-1:0] load_s2;
    logic [CW-1:0] pulse_cnt;
    logic [DW-1:0] q;
  } prom_state_s;

  prom_state_s st_ff;
  prom_state_s nxt_st;
  logic rclk_rise;
  logic pulse_ok;
  logic fire;
  logic [DW-1:0] word_sel;

  function automatic logic one_hot(input logic [DW-1:0] v);
    logic [DW:0] n;
    n = '0;
    for (int i = 0; i < DW; i++) begin
      n = n + (DW+1)'(v[i]);
    end
    return n == (DW+1)'(1);
  endfunction : one_hot

  // long enough pulse has just fallen with a single loaded output
  function automatic logic blow_ready(
    input logic sup_was,
    input logic sup_now,
    input logic [CW-1:0] cnt,
    input logic [DW-1:0] load
  );
    return sup_was && !sup_now && (cnt >= PULSE_MIN_CYC) && one_hot(load);
  endfunction : blow_ready

  // pulse has just fallen before reaching the minimum width
  function automatic logic short_end(
    input logic sup_was,
    input logic sup_now,
    input logic [CW-1:0] cnt
  );
    return sup_was && !sup_now && (cnt < PULSE_MIN_CYC);
  endfunction : short_end

  assign word_sel = st_ff.fuse[st_ff.addr_s2];
  assign rclk_rise = st_ff.rclk_s2 && !st_ff.rclk_d;
  assign pulse_ok = st_ff.sup_s2 && st_ff.oe_n_s2 && one_hot(st_ff.load_s2);
  assign fire = blow_ready(st_ff.sup_d, st_ff.sup_s2, st_ff.pulse_cnt, st_ff.load_s2);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.addr_s1 = word_address;
    nxt_st.addr_s2 = st_ff.addr_s1;
    nxt_st.rclk_s1 = reg_load_clk;
    nxt_st.rclk_s2 = st_ff.rclk_s1;
    nxt_st.rclk_d = st_ff.rclk_s2;
    nxt_st.oe_n_s1 = output_enable_n;
    nxt_st.oe_n_s2 = st_ff.oe_n_s1;
    nxt_st.sup_s1 = program_supply_pulse;
    nxt_st.sup_s2 = st_ff.sup_s1;
    nxt_st.sup_d = st_ff.sup_s2;
    nxt_st.load_s1 = program_load;
    nxt_st.load_s2 = st_ff.load_s1;
    // pulse timer: counts only a deselected pulse with a single loaded output
    if (pulse_ok) begin
      if (st_ff.pulse_cnt != '1) begin
        nxt_st.pulse_cnt = st_ff.pulse_cnt + CW'(1);
      end
    end else if (!st_ff.sup_s2) begin
      nxt_st.pulse_cnt = '0;
    end else begin
      nxt_st.pulse_cnt = '0;
    end
    if (fire) begin
      nxt_st.fuse[st_ff.addr_s2] = word_sel | st_ff.load_s2;
    end
    if (rclk_rise) begin
      nxt_st.q = word_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign data_outputs = st_ff.q;
  assign data_outputs_oe = {DW{!st_ff.oe_n_s2}};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rclk_rise;
    !st_ff.rclk_d ##0 st_ff.rclk_s2;
  endsequence

  sequence s_pulse_end;
    blow_ready(st_ff.sup_d, st_ff.sup_s2, st_ff.pulse_cnt, st_ff.load_s2);
  endsequence

  a_reg_load_word: assert property (s_rclk_rise |=> data_outputs == $past(word_sel))
    else $error("output register did not take addressed word");
  a_hold_no_edge: assert property (!rclk_rise |=> $stable(data_outputs))
    else $error("output register changed without load edge");
  a_float_off: assert property (st_ff.oe_n_s2 |-> data_outputs_oe == '0)
    else $error("outputs driven while disabled");
  a_drive_on: assert property (!st_ff.oe_n_s2 |-> (&data_outputs_oe) && data_outputs == st_ff.q)
    else $error("outputs not driving register");
  a_fuse_sticky: assert property (($past(st_ff.fuse) & ~st_ff.fuse) == '0)
    else $error("blown fuse returned low");
  a_fuse_target: assert property (s_pulse_end |=>
    st_ff.fuse[$past(st_ff.addr_s2)] == $past(word_sel | st_ff.load_s2))
    else $error("pulse did not blow addressed bit");

  sequence s_short_end;
    short_end(st_ff.sup_d, st_ff.sup_s2, st_ff.pulse_cnt);
  endsequence

  sequence s_enable_low;
    !st_ff.oe_n_s2;
  endsequence

  sequence s_bad_load;
    st_ff.sup_s2 ##0 !one_hot(st_ff.load_s2);
  endsequence

  a_short_no_blow: assert property (s_short_end |=> st_ff.fuse == $past(st_ff.fuse))
    else $error("short pulse changed a fuse");

  a_enabled_no_count: assert property (s_enable_low |=> st_ff.pulse_cnt == '0)
    else $error("pulse counted while outputs enabled");

  a_bad_load_no_count: assert property (s_bad_load |=> st_ff.pulse_cnt == '0)
    else $error("pulse counted without a single load");

  // one pulse blows one bit at most
  a_blow_one_bit: assert property (fire |=>
    $countones(st_ff.fuse ^ $past(st_ff.fuse)) <= 1)
    else $error("pulse changed more than one fuse");

  a_count_steps: assert property ((pulse_ok && (st_ff.pulse_cnt != '1)) |=>
    st_ff.pulse_cnt == $past(st_ff.pulse_cnt) + CW'(1))
    else $error("pulse timer skipped a step");

  sequence s_pin_off;
    output_enable_n [*3];
  endsequence

  sequence s_pin_on;
    !output_enable_n [*3];
  endsequence

  a_pin_float: assert property (s_pin_off |-> data_outputs_oe == '0)
    else $error("outputs still driven after enable went high");

  a_pin_drive: assert property (s_pin_on |-> (&data_outputs_oe))
    else $error("outputs not driven after enable went low");

  sequence s_clk_pin_rise;
    !reg_load_clk ##1 reg_load_clk;
  endsequence

  a_pin_load_word: assert property (s_clk_pin_rise |-> ##3 data_outputs == $past(word_sel))
    else $error("load pin edge did not load addressed word");
endmodule : registered_prom_read_program

// *** fuse_programmer.sv ***
module fuse_programmer (
  input wire logic sys_clk,
  output logic oe_n,
  output logic supply,
  output logic [3:0] load
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    oe_n = 0;
    supply = 0;
    load = '0;
  end
  task automatic pulse(input logic [3:0] sel, input int cyc);
    @(posedge sys_clk);
    #1 oe_n = 1;
    repeat (16) @(posedge sys_clk);
    #1 load = sel;
    supply = 1;
    repeat (cyc) @(posedge sys_clk);
    #1 supply = 0;
    repeat (16) @(posedge sys_clk);
    #1 load = '0;
    oe_n = 0;
  endtask : pulse
endmodule : fuse_programmer

// *** registered_prom_read_program_tb.sv ***
module registered_prom_read_program_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import prom_pkg::*;
  logic sys_clk, rst_n, rclk, oe_n, supply;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] load, dout, doe;
  int num_errors = 0;
  int check_count = 0;
  typedef struct {logic [11:0] a; logic [3:0] s; logic [3:0] e;} row_s;
  row_s rows [4] = '{'{12'h000, 4'h2, 4'h2}, '{12'hFFF, 4'h8, 4'h8},
    '{12'h000, 4'h4, 4'h6}, '{12'hFFF, 4'h8, 4'h8}};
  registered_prom_read_program #(.PULSE_MIN_CYC(12'h014)) dut_u (.sys_clk(sys_clk),
    .rst_n(rst_n), .word_address(addr), .reg_load_clk(rclk), .output_enable_n(oe_n),
    .program_supply_pulse(supply), .program_load(load), .data_outputs(dout),
    .data_outputs_oe(doe));
  fuse_programmer prog_u (.sys_clk(sys_clk), .oe_n(oe_n), .supply(supply), .load(load));
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input string n, input logic [3:0] s, input logic [3:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : check
  task automatic prog(input logic [11:0] a, input logic [3:0] s, input int cyc);
    @(posedge sys_clk);
    #1 addr = a;
    prog_u.pulse(s, cyc);
  endtask : prog
  task automatic read(input logic [11:0] a, input logic [3:0] e);
    @(posedge sys_clk);
    #1 addr = a;
    repeat (4) @(posedge sys_clk);
    #1 rclk = 1;
    repeat (3) @(posedge sys_clk);
    #1 rclk = 0;
    repeat (3) @(posedge sys_clk);
    #1 check("data", dout, e);
    check("oe", doe, 4'hF);
  endtask : read
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  initial begin
    rst_n = 0;
    rclk = 0;
    addr = '0;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1;
    read(12'h000, 4'h0);
    foreach (rows[i]) begin
      prog(rows[i].a, rows[i].s, 24);
      read(rows[i].a, rows[i].e);
    end
    prog(12'h001, 4'h1, 10);
    prog(12'h001, 4'h3, 24);
    read(12'h001, 4'h0);
    prog(12'h001, 4'h1, 24);
    read(12'h001, 4'h1);
    @(posedge sys_clk);
    #1 prog_u.oe_n = 1;
    repeat (4) @(posedge sys_clk);
    #1 check("float", doe, 4'h0);
    prog_u.oe_n = 0;
    read(12'hFFF, 4'h8);
    read(12'h000, 4'h6);
    conclude();
  end
endmodule : registered_prom_read_program_tb
